// ===== offset_trim.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module offset_trim #(
  parameter int PROG_CYCLES = trim_pkg::NVM_PROG_CYCLES
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [7:0]          reg_rdata,
  input  wire logic [4:0]     bw_code,
  input  wire trim_pkg::axes_t raw_in,
  input  wire logic           raw_valid,
  input  wire trim_pkg::axes_t filt_in,
  input  wire logic           filt_valid,
  output trim_pkg::axes_t     raw_out,
  output logic                raw_out_valid,
  output trim_pkg::axes_t     filt_out,
  output logic                filt_out_valid
);
  import trim_pkg::*;

  localparam int ACC_W = 14 + FRAC_BITS;

  typedef enum {F_IDLE, F_RUN} fast_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [13:0] axis_of(input axes_t a, input int i);
    if (i == 0) return a.x;
    else if (i == 1) return a.y;
    else return a.z;
  endfunction : axis_of

  function automatic logic signed [13:0] target_of(input logic [1:0] t);
    case (t)
      2'b01:   return ONE_G;
      2'b10:   return -ONE_G;
      default: return 14'sd0;
    endcase
  endfunction : target_of

  // Approximate high-pass step as a shift; one step per raw sample
  function automatic logic [4:0] hp_shift(input logic [4:0] bw, input logic cut);
    logic [4:0] s;
    if (bw[4]) s = HP_SHIFT_RAW;
    else if (!bw[3]) s = HP_SHIFT_MAX;
    else s = HP_SHIFT_MAX - {2'b00, bw[2:0]};
    if (cut) s = s - HP_CUT_STEP;
    return s;
  endfunction : hp_shift

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic signed [ACC_W-1:0] acc_q [3];
  logic signed [ACC_W-1:0] acc_d [3];
  logic [7:0]              trim_reg_q [3];
  logic [7:0]              trim_reg_d [3];
  logic [7:0]              gen_q [2];
  logic [2:0]              hp_en_q;
  logic [7:0]              param_q;
  logic                    unlock_q;
  fast_state_t             fast_q;
  logic [1:0]              fast_axis_q;
  logic [3:0]              fast_cnt_q;
  logic signed [17:0]      fast_sum_q;
  logic signed [13:0]      trim14 [3];
  logic signed [13:0]      corr_raw [3];
  logic                    wr_nvm, wr_ctrl, wr_param;
  logic                    trim_clear, fast_start, fast_done;
  logic signed [17:0]      fast_sum_final;
  logic signed [13:0]      fast_value;
  logic                    load_req, prog_req, load_done, load_busy, prog_busy;
  logic                    nvm_ready, fast_ready;
  image_t                  image_out;
  logic [3:0]              remain;
  logic [4:0]              hp_s;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  assign wr_nvm     = reg_wr && reg_addr == ADDR_NVM_CTRL;
  assign wr_ctrl    = reg_wr && reg_addr == ADDR_TRIM_CTRL;
  assign wr_param   = reg_wr && reg_addr == ADDR_TRIM_PARAM;
  assign trim_clear = wr_ctrl && reg_wdata[TRIM_CLEAR_BIT];
  // A trigger of 00 starts nothing; a request while busy is dropped
  assign fast_start = wr_ctrl && reg_wdata[FAST_TRIG_LSB +: 2] != 2'b00 && fast_q == F_IDLE;
  // Reload refused while the store is busy, to avoid tearing a write
  assign load_req   = wr_nvm && reg_wdata[NVM_RELOAD_BIT] && !load_busy && !prog_busy;
  // Trigger counts only if unlock was already set and stays set
  assign prog_req   = wr_nvm && reg_wdata[NVM_PROG_BIT] && reg_wdata[NVM_UNLOCK_BIT]
                      && unlock_q && !load_busy && !prog_busy;
  assign nvm_ready  = !load_busy && !prog_busy;
  assign fast_ready = fast_q == F_IDLE;
  assign hp_s       = hp_shift(bw_code, param_q[CUT_OFF_BIT]);

  // Backing store; a reset starts a reload by itself
  nvm_backup #(
    .LOAD_CYCLES (NVM_LOAD_CYCLES),
    .PROG_CYCLES (PROG_CYCLES)
  ) u_nvm (
    .clk       (clk),
    .srst      (srst),
    .load_req  (load_req),
    .prog_req  (prog_req),
    .image_in  ({gen_q[1], gen_q[0], trim_reg_q[2], trim_reg_q[1], trim_reg_q[0]}),
    .load_done (load_done),
    .load_busy (load_busy),
    .prog_busy (prog_busy),
    .image_out (image_out),
    .remain    (remain)
  );

  // ----------------------------------------------------------------
  // Correction of both streams
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      trim14[i]   = acc_q[i][ACC_W-1 -: 14];
      corr_raw[i] = sat14(18'(axis_of(raw_in, i)) + 18'(trim14[i]));
    end
  end

  // Same trim on filtered data as on raw data
  always_ff @(posedge clk) begin
    if (srst) begin
      raw_out        <= '0;
      filt_out       <= '0;
      raw_out_valid  <= 1'b0;
      filt_out_valid <= 1'b0;
    end else begin
      raw_out_valid  <= raw_valid;
      filt_out_valid <= filt_valid;
      if (raw_valid) raw_out <= '{corr_raw[0], corr_raw[1], corr_raw[2]};
      if (filt_valid) begin
        filt_out.x <= sat14(18'(filt_in.x) + 18'(trim14[0]));
        filt_out.y <= sat14(18'(filt_in.y) + 18'(trim14[1]));
        filt_out.z <= sat14(18'(filt_in.z) + 18'(trim14[2]));
      end
    end
  end

  // ----------------------------------------------------------------
  // Fast compensation
  // ----------------------------------------------------------------
  assign fast_done      = fast_q == F_RUN && raw_valid && fast_cnt_q == FAST_LAST;
  assign fast_sum_final = fast_sum_q + 18'(axis_of(raw_in, int'(fast_axis_q) - 1));
  assign fast_value     = sat14(18'(target_of(param_q[TARGET_X_LSB + 2 * (int'(fast_axis_q) - 1) +: 2]))
                                - (fast_sum_final >>> FAST_SHIFT));

  always_ff @(posedge clk) begin
    if (srst) begin
      fast_q      <= F_IDLE;
      fast_axis_q <= 2'b00;
      fast_cnt_q  <= 4'h0;
      fast_sum_q  <= '0;
    end else begin
      case (fast_q)
        F_IDLE: begin
          if (fast_start) begin
            fast_q      <= F_RUN;
            fast_axis_q <= reg_wdata[FAST_TRIG_LSB +: 2];
            fast_cnt_q  <= 4'h0;
            fast_sum_q  <= '0;
          end
        end
        F_RUN: begin
          if (raw_valid) begin
            fast_sum_q <= fast_sum_final;
            fast_cnt_q <= fast_cnt_q + 1'b1;
            if (fast_done) fast_q <= F_IDLE;
          end
        end
        default: fast_q <= F_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trim values: internal accumulator and visible register
  // ----------------------------------------------------------------
  // Priority: clear, reload, software write, fast result, high-pass step
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      acc_d[i]      = acc_q[i];
      trim_reg_d[i] = trim_reg_q[i];
      if (trim_clear) begin
        acc_d[i]      = '0;
        trim_reg_d[i] = TRIM_RESET;
      end else if (load_done) begin
        trim_reg_d[i] = image_out[i];
        acc_d[i]      = {widen14(image_out[i]), {FRAC_BITS{1'b0}}};
      end else if (reg_wr && reg_addr == ADDR_X_TRIM + 8'(i)) begin
        trim_reg_d[i] = reg_wdata;
        acc_d[i]      = {widen14(reg_wdata), {FRAC_BITS{1'b0}}};
      end else if (fast_done && int'(fast_axis_q) == i + 1) begin
        acc_d[i]      = {fast_value, {FRAC_BITS{1'b0}}};
        trim_reg_d[i] = narrow8(fast_value);
      end else if (raw_valid && hp_en_q[i] && fast_q == F_IDLE) begin
        // Fraction bits keep the slow drift from stalling at small steps
        acc_d[i]      = acc_q[i] - ({{(ACC_W-14){corr_raw[i][13]}}, corr_raw[i]}
                                    <<< (5'(FRAC_BITS) - hp_s));
        trim_reg_d[i] = narrow8(acc_d[i][ACC_W-1 -: 14]);
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        acc_q[i]      <= '0;
        trim_reg_q[i] <= TRIM_RESET;
      end else begin
        acc_q[i]      <= acc_d[i];
        trim_reg_q[i] <= trim_reg_d[i];
      end
    end
  end

  // General-purpose bytes: plain storage with backup
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (srst) gen_q[i] <= 8'h00;
      else if (load_done) gen_q[i] <= image_out[3 + i];
      else if (reg_wr && reg_addr == ADDR_GEN_0 + 8'(i)) gen_q[i] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      hp_en_q  <= HP_EN_RESET;
      param_q  <= PARAM_RESET;
      unlock_q <= 1'b0;
    end else begin
      if (wr_ctrl) hp_en_q <= reg_wdata[2:0];
      if (wr_param) param_q <= reg_wdata;
      if (wr_nvm) unlock_q <= reg_wdata[NVM_UNLOCK_BIT];
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_NVM_CTRL:   reg_rdata <= {remain, 1'b0, nvm_ready, 1'b0, unlock_q};
        ADDR_TRIM_CTRL:  reg_rdata <= {3'b000, fast_ready, 1'b0, hp_en_q};
        ADDR_TRIM_PARAM: reg_rdata <= param_q;
        ADDR_X_TRIM:     reg_rdata <= trim_reg_q[0];
        ADDR_Y_TRIM:     reg_rdata <= trim_reg_q[1];
        ADDR_Z_TRIM:     reg_rdata <= trim_reg_q[2];
        ADDR_GEN_0:      reg_rdata <= gen_q[0];
        ADDR_GEN_1:      reg_rdata <= gen_q[1];
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_x_write;
    reg_wr && reg_addr == ADDR_X_TRIM && !trim_clear && !load_done;
  endsequence

  sequence s_clear;
    trim_clear;
  endsequence

  // Half of the shortest possible run: sixteen back-to-back samples
  sequence s_run_half;
    !fast_ready [*8];
  endsequence

  a_raw_clamped: assert property (@(posedge clk) disable iff (srst)
    raw_valid |=> raw_out_valid && raw_out.x == sat14(18'($past(raw_in.x)) + 18'($past(trim14[0]))))
    else $error("raw output not corrected and clamped");

  a_filt_corrected: assert property (@(posedge clk) disable iff (srst)
    filt_valid |=> filt_out_valid && filt_out.z == sat14(18'($past(filt_in.z)) + 18'($past(trim14[2]))))
    else $error("filtered output not corrected");

  a_write_widened: assert property (@(posedge clk) disable iff (srst)
    s_x_write |=> trim14[0] == widen14($past(reg_wdata)) && trim_reg_q[0] == $past(reg_wdata))
    else $error("written trim not widened");

  a_fast_narrowed: assert property (@(posedge clk) disable iff (srst)
    fast_done && fast_axis_q == 2'b01 && !trim_clear && !load_done
    |=> trim_reg_q[0] == narrow8(trim14[0]) && trim14[0] == $past(fast_value))
    else $error("fast result not stored on x");

  a_load_copies: assert property (@(posedge clk) disable iff (srst)
    load_done && !trim_clear |=> trim_reg_q[1] == $past(image_out[1]) && gen_q[0] == $past(image_out[3]))
    else $error("image update did not copy backup");

  a_clear_zero: assert property (@(posedge clk) disable iff (srst)
    s_clear |=> trim_reg_q[0] == 8'h00 && trim_reg_q[1] == 8'h00 && trim_reg_q[2] == 8'h00)
    else $error("trim clear left a value");

  a_slow_disabled: assert property (@(posedge clk) disable iff (srst)
    raw_valid && !hp_en_q[2] && !reg_wr && !load_done && !(fast_done && fast_axis_q == 2'b11)
    |=> $stable(acc_q[2]))
    else $error("disabled axis drifted");

  a_fast_busy: assert property (@(posedge clk) disable iff (srst)
    fast_start |=> s_run_half ##1 s_run_half)
    else $error("done flag high during fast run");

  a_reload_busy: assert property (@(posedge clk) disable iff (srst)
    load_req |=> !nvm_ready [*2])
    else $error("ready flag high during reload");

  a_prog_started: assert property (@(posedge clk) disable iff (srst)
    wr_nvm && reg_wdata[1:0] == 2'b11 && unlock_q && nvm_ready |=> prog_busy && !nvm_ready)
    else $error("unlocked trigger did not start write");

  a_trigger_unread: assert property (@(posedge clk) disable iff (srst)
    reg_rd && reg_addr == ADDR_TRIM_CTRL |=> reg_rdata[FAST_TRIG_LSB +: 2] == 2'b00 && !reg_rdata[TRIM_CLEAR_BIT])
    else $error("write-only trim control bits read back");

  a_prog_refused: assert property (@(posedge clk) disable iff (srst)
    wr_nvm && reg_wdata[NVM_PROG_BIT] && !reg_wdata[NVM_RELOAD_BIT] && !unlock_q && nvm_ready |=> nvm_ready)
    else $error("locked trigger started a write");

endmodule : offset_trim

// ===== trim_pkg.sv
package trim_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_NVM_CTRL   = 8'h33;
  localparam logic [7:0] ADDR_TRIM_CTRL  = 8'h36;
  localparam logic [7:0] ADDR_TRIM_PARAM = 8'h37;
  localparam logic [7:0] ADDR_X_TRIM     = 8'h38;
  localparam logic [7:0] ADDR_Y_TRIM     = 8'h39;
  localparam logic [7:0] ADDR_Z_TRIM     = 8'h3a;
  localparam logic [7:0] ADDR_GEN_0      = 8'h3b;
  localparam logic [7:0] ADDR_GEN_1      = 8'h3c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NVM_UNLOCK_BIT  = 0;
  localparam int NVM_PROG_BIT    = 1;
  localparam int NVM_READY_BIT   = 2;
  localparam int NVM_RELOAD_BIT  = 3;
  localparam int NVM_REMAIN_LSB  = 4;
  localparam int FAST_DONE_BIT   = 4;
  localparam int FAST_TRIG_LSB   = 5;
  localparam int TRIM_CLEAR_BIT  = 7;
  localparam int CUT_OFF_BIT     = 0;
  localparam int TARGET_X_LSB    = 1;
  localparam int TARGET_Y_LSB    = 3;
  localparam int TARGET_Z_LSB    = 5;

  // ----------------------------------------------------------------
  // Reset values, sizes and arithmetic constants
  // ----------------------------------------------------------------
  localparam int         IMAGE_BYTES   = 5;
  localparam logic [3:0] REMAIN_INIT   = 4'hf;
  localparam logic [7:0] TRIM_RESET    = 8'h00;
  localparam logic [2:0] HP_EN_RESET   = 3'h0;
  localparam logic [7:0] PARAM_RESET   = 8'h00;
  localparam int         FRAC_BITS     = 16;
  localparam int         WIDEN_SHIFT   = 5;
  localparam int         FAST_SAMPLES  = 16;
  localparam logic [3:0] FAST_LAST     = 4'hf;
  localparam int         FAST_SHIFT    = 4;
  localparam logic signed [13:0] ONE_G = 14'sd4096;
  localparam logic [4:0] HP_SHIFT_MAX  = 5'd16;
  localparam logic [4:0] HP_SHIFT_RAW  = 5'd9;
  localparam logic [4:0] HP_CUT_STEP   = 5'd3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 5;
  localparam int NVM_LOAD_NS      = 1000;
  localparam int NVM_PROG_NS      = 5000000;
  localparam int NVM_LOAD_CYCLES  = (NVM_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVM_PROG_CYCLES  = (NVM_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [13:0] x;
    logic signed [13:0] y;
    logic signed [13:0] z;
  } axes_t;

  typedef logic [IMAGE_BYTES-1:0][7:0] image_t;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  // Clamp a wide sum into the 14-bit output word
  function automatic logic signed [13:0] sat14(input logic signed [17:0] v);
    if (v > 18'sd8191) return 14'sd8191;
    else if (v < -18'sd8192) return -14'sd8192;
    else return v[13:0];
  endfunction : sat14

  // 8-bit register view to 14-bit internal value
  function automatic logic signed [13:0] widen14(input logic [7:0] b);
    return {b[7], b, 5'h00};
  endfunction : widen14

  // 14-bit internal value to 8-bit register view, saturated
  function automatic logic [7:0] narrow8(input logic signed [13:0] v);
    logic signed [13:0] s;
    s = v >>> WIDEN_SHIFT;
    if (s > 14'sd127) return 8'h7f;
    else if (s < -14'sd128) return 8'h80;
    else return s[7:0];
  endfunction : narrow8

endpackage : trim_pkg

// ===== nvm_backup.sv
`timescale 1ns/100ps
// Non-volatile backing store for the five image bytes
module nvm_backup #(
  parameter int LOAD_CYCLES = trim_pkg::NVM_LOAD_CYCLES,
  parameter int PROG_CYCLES = trim_pkg::NVM_PROG_CYCLES
) (
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            load_req,
  input  wire logic            prog_req,
  input  wire trim_pkg::image_t image_in,
  output logic                 load_done,
  output logic                 load_busy,
  output logic                 prog_busy,
  output trim_pkg::image_t     image_out,
  output logic [3:0]           remain
);
  import trim_pkg::*;

  localparam int CNT_W = $clog2(PROG_CYCLES + LOAD_CYCLES + 1);

  typedef enum {NV_LOAD, NV_IDLE, NV_PROG} nv_state_t;

  nv_state_t        state_q;
  logic [CNT_W-1:0] cnt_q;
  // Content survives the synchronous reset; only power-up clears it
  image_t           store_q  = '0;
  logic [3:0]       remain_q = REMAIN_INIT;

  // ----------------------------------------------------------------
  // Sequencer: reset always begins with an image load
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= NV_LOAD;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        NV_IDLE: begin
          cnt_q <= '0;
          if (prog_req) state_q <= NV_PROG;
          else if (load_req) state_q <= NV_LOAD;
        end
        NV_LOAD: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(LOAD_CYCLES - 1)) state_q <= NV_IDLE;
        end
        NV_PROG: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(PROG_CYCLES - 1)) state_q <= NV_IDLE;
        end
        default: state_q <= NV_IDLE;
      endcase
    end
  end

  // Whole content captured at the start of a write
  always_ff @(posedge clk) begin
    if (!srst && state_q == NV_IDLE && prog_req) begin
      store_q <= image_in;
      if (remain_q != 4'h0) remain_q <= remain_q - 1'b1;
    end
  end

  assign load_busy = (state_q == NV_LOAD);
  assign prog_busy = (state_q == NV_PROG);
  assign load_done = load_busy && cnt_q == CNT_W'(LOAD_CYCLES - 1);
  assign image_out = store_q;
  assign remain    = remain_q;

endmodule : nvm_backup

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
  import trim_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk, srst, reg_wr, reg_rd, raw_valid, filt_valid, raw_out_valid, filt_out_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [4:0] bw_code;
  axes_t      raw_in, filt_in, raw_out, filt_out;
  int         n_fail, compares;

  // Short store write time keeps the run brief
  offset_trim #(.PROG_CYCLES(20)) i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bw_code(bw_code), .raw_in(raw_in), .raw_valid(raw_valid), .filt_in(filt_in),
    .filt_valid(filt_valid), .raw_out(raw_out), .raw_out_valid(raw_out_valid),
    .filt_out(filt_out), .filt_out_valid(filt_out_valid));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Same value on all axes of both streams; full-rate data only, never low power
  task automatic smp(input logic signed [13:0] v);
    @(posedge clk);
    raw_valid  <= 1'b1;
    filt_valid <= 1'b1;
    raw_in     <= '{v, v, v};
    filt_in    <= '{v, v, v};
    @(posedge clk);
    raw_valid  <= 1'b0;
    filt_valid <= 1'b0;
    #1;
  endtask : smp

  // Bounded poll; a hang counts as a mismatch
  task automatic wait_ready;
    for (int i = 0; i < 300; i++) begin
      rd(ADDR_NVM_CTRL, d);
      if (d[NVM_READY_BIT] === 1'b1) return;
    end
    n_fail++;
    final_report();
  endtask : wait_ready

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(ADDR_NVM_CTRL, d);
    chk(14'(d[NVM_READY_BIT]), 14'h0000);
    wait_ready();
    rd(ADDR_NVM_CTRL, d);
    chk(14'(d), 14'h00f4);
    rd(ADDR_X_TRIM, d);
    chk(14'(d), 14'h0000);
    rd(8'h40, d);
    chk(14'(d), 14'h0000);
  endtask : t_reset

  task automatic t_manual;
    wr(ADDR_X_TRIM, 8'h10);
    smp(14'sd100);
    chk(raw_out.x, 14'sd612);
    chk(filt_out.x, 14'sd612);
    chk(raw_out.y, 14'sd100);
    chk(filt_out.z, 14'sd100);
    chk(14'(raw_out_valid), 14'h0001);
    chk(14'(filt_out_valid), 14'h0001);
    wr(ADDR_X_TRIM, 8'h7f);
    smp(14'sd8000);
    chk(raw_out.x, 14'sd8191);
    wr(ADDR_X_TRIM, 8'h80);
    smp(-14'sd8000);
    chk(filt_out.x, -14'sd8192);
  endtask : t_manual

  // Clear with a trigger of 00, which must start nothing
  task automatic t_clear;
    wr(ADDR_Y_TRIM, 8'h22);
    wr(ADDR_TRIM_CTRL, 8'h80);
    rd(ADDR_Y_TRIM, d);
    chk(14'(d), 14'h0000);
    rd(ADDR_X_TRIM, d);
    chk(14'(d), 14'h0000);
    rd(ADDR_TRIM_CTRL, d);
    chk(14'(d), 14'h0010);
  endtask : t_clear

  // Slow step at bandwidth code 0x0e: two samples per cut-off setting, x enabled only
  task automatic t_slow;
    wr(ADDR_TRIM_CTRL, 8'h01);
    smp(14'sd4096);
    smp(14'sd4096);
    rd(ADDR_X_TRIM, d);
    chk(14'(d), 14'h00ff);
    rd(ADDR_Y_TRIM, d);
    chk(14'(d), 14'h0000);
    wr(ADDR_TRIM_PARAM, 8'h01);
    wr(ADDR_X_TRIM, 8'h00);
    smp(14'sd4096);
    smp(14'sd4096);
    chk(raw_out.x, 14'sd4064);
    rd(ADDR_X_TRIM, d);
    chk(14'(d), 14'h00fe);
    rd(ADDR_Z_TRIM, d);
    chk(14'(d), 14'h0000);
  endtask : t_slow

  // Targets +1g, -1g (saturates), 0g by code 11, against a mean of 1024, a quarter g
  task automatic t_fast;
    logic [1:0] tcode [3] = '{2'h1, 2'h2, 2'h3};
    logic [7:0] exp   [3] = '{8'h60, 8'h80, 8'he0};
    for (int ax = 1; ax <= 3; ax++) begin
      wr(ADDR_TRIM_PARAM, 8'(tcode[ax-1]) << (2 * ax - 1));
      wr(ADDR_TRIM_CTRL, 8'(ax << FAST_TRIG_LSB));
      rd(ADDR_TRIM_CTRL, d);
      chk(14'(d), 14'h0000);
      // No trim writes while the run is going
      for (int i = 0; i < FAST_SAMPLES; i++) smp(14'sd1024);
      rd(ADDR_TRIM_CTRL, d);
      chk(14'(d), 14'h0010);
      rd(8'(ADDR_X_TRIM + ax - 1), d);
      chk(14'(d), 14'(exp[ax-1]));
    end
  endtask : t_fast

  task automatic t_nvm;
    wr(ADDR_GEN_0, 8'h5a);
    wr(ADDR_NVM_CTRL, 8'h01);
    wr(ADDR_NVM_CTRL, 8'h03);
    rd(ADDR_NVM_CTRL, d);
    chk(14'(d[NVM_READY_BIT]), 14'h0000);
    wait_ready();
    rd(ADDR_NVM_CTRL, d);
    chk(14'(d), 14'h00e5);
    wr(ADDR_GEN_0, 8'h00);
    wr(ADDR_X_TRIM, 8'h00);
    wr(ADDR_NVM_CTRL, 8'h09);
    rd(ADDR_NVM_CTRL, d);
    chk(14'(d[NVM_READY_BIT]), 14'h0000);
    wait_ready();
    rd(ADDR_GEN_0, d);
    chk(14'(d), 14'h005a);
    rd(ADDR_X_TRIM, d);
    chk(14'(d), 14'h0060);
  endtask : t_nvm

  // Mid-run reset: stored bytes and write count survive, unlock does not
  task automatic t_rerun;
    wr(ADDR_X_TRIM, 8'h11);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wait_ready();
    rd(ADDR_X_TRIM, d);
    chk(14'(d), 14'h0060);
    rd(ADDR_NVM_CTRL, d);
    chk(14'(d), 14'h00e4);
    wr(ADDR_NVM_CTRL, 8'h03);
    rd(ADDR_NVM_CTRL, d);
    chk(14'(d), 14'h00e5);
  endtask : t_rerun

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst       = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    bw_code    = 5'h0e;
    raw_valid  = 1'b0;
    filt_valid = 1'b0;
    raw_in     = '0;
    filt_in    = '0;
    n_fail     = 0;
    compares   = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_manual();
    t_clear();
    t_slow();
    t_fast();
    t_nvm();
    t_rerun();
    final_report();
  end
endmodule : testbench
